// >>> hppsc_pkg.sv
/*
  Shared constants for the hub port power and speed control block.
  Assumes one clock (clk) and a synchronous active-low reset.
*/
// Notes on behaviour
// - Upstream limited to high or full speed: no SuperSpeed offered downstream.
// - Upstream limited to full/low speed: no SuperSpeed nor high speed downstream.
// - One to four downstream ports reported, from straps, EEPROM or SMBus.
// - Each port separately enabled, removable or fixed, charging on or off.
// - Ganged power: all ports powered once any port needs power; only requests from enabled, reported ports count here.
// - Power stays on until every port allows power removal; disabled or unreported ports are not waited on here.
// - Over-current removes power from all ports together.
// - Status and command register never written from EEPROM load data.
// - Reset asserted: block inactive, all registers at default values.
// - Drive high-speed and SuperSpeed upstream connected and suspended outputs.
// - One translator per port, four asynchronous endpoint buffers each.
// - All logic timed from the single reference clock.
// - SMBus slave address configurable for several devices per segment.
// - A 128-bit unique identifier is exposed.
package hppsc_pkg;
  localparam int          NUM_PORTS      = 4;
  localparam int          TT_BUFFERS     = 4;
  localparam int          UUID_W         = 128;
  localparam int          SMB_ADDR_W     = 7;
  localparam logic [7:0]  DSC_OFFSET     = 8'hf8;
  localparam logic [7:0]  DSC_RESET      = 8'h00;
  localparam int          DSC_CFG_ACTIVE = 0;
  localparam int          DSC_SMB_RESET  = 1;
  localparam logic [7:0]  DSC_RW_MASK    = 8'h03;
  localparam int          CLK_HZ         = 10_000_000;
  // Arbitrary neutral identifier value
  localparam logic [127:0] UUID_DEFAULT  = 128'h0123456789abcdef0123456789abcdef;

  typedef enum logic [2:0] {
    HPPSC_LNK_FS = 3'h1,
    HPPSC_LNK_HS = 3'h2,
    HPPSC_LNK_SS = 3'h4
  } hppsc_link_e;
endpackage : hppsc_pkg

// >>> hppsc_sync.sv
/*
  Two-flop synchroniser for a bus of levels.
  Assumes inputs are unrelated to clk.
*/
module hppsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hppsc_sync_s;
  hppsc_sync_s st_ff;
  hppsc_sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule : hppsc_sync

// >>> hppsc_top.sv
/*
  Hub control: downstream speed limits, port configuration, ganged power
  with latched over-current, upstream status outputs, status/command
  register. Assumes pins are asynchronous and pass synchronisers; the
  register port is a simple same-clock strobe interface.
*/
module hppsc_top
  import hppsc_pkg::*;
#(
  parameter int NPORTS = hppsc_pkg::NUM_PORTS
) (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic [2:0]                       up_link_caps,
  input  wire logic                             up_hs_connected,
  input  wire logic                             up_hs_suspended,
  input  wire logic                             up_ss_connected,
  input  wire logic                             up_ss_suspended,
  input  wire logic [NPORTS-1:0]                strap_port_disable,
  input  wire logic [NPORTS-1:0]                strap_port_fixed,
  input  wire logic [NPORTS-1:0]                strap_port_charge,
  input  wire logic [hppsc_pkg::SMB_ADDR_W-1:0] strap_smb_addr,
  input  wire logic                             cfg_wr,
  input  wire logic                             cfg_from_eeprom,
  input  wire logic [2:0]                       cfg_num_ports,
  input  wire logic [NPORTS-1:0]                cfg_port_disable,
  input  wire logic [NPORTS-1:0]                cfg_port_fixed,
  input  wire logic [NPORTS-1:0]                cfg_port_charge,
  input  wire logic [hppsc_pkg::SMB_ADDR_W-1:0] cfg_smb_addr,
  input  wire logic                             reg_wr,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [7:0]                       reg_wdata,
  output logic      [7:0]                       reg_rdata,
  input  wire logic [NPORTS-1:0]                port_power_req,
  input  wire logic [NPORTS-1:0]                port_power_release_ok,
  input  wire logic                             over_current_n,
  input  wire logic                             host_power_enable,
  output logic      [NPORTS-1:0]                port_ss_enable,
  output logic      [NPORTS-1:0]                port_hs_enable,
  output logic      [NPORTS-1:0]                port_enabled,
  output logic      [NPORTS-1:0]                port_removable,
  output logic      [NPORTS-1:0]                charging_downstream_port,
  output logic      [2:0]                       ports_reported,
  output logic                                  port_power_on,
  output logic                                  over_current_latched,
  output logic                                  hs_up_connected,
  output logic                                  hs_up_suspended,
  output logic                                  ss_up_connected,
  output logic                                  ss_up_suspended,
  output logic [hppsc_pkg::SMB_ADDR_W-1:0]      smb_address,
  output logic [hppsc_pkg::UUID_W-1:0]          uuid,
  output logic [2:0]                            multi_translator_hub
);
  import hppsc_pkg::*;

  localparam int SYNC_W = 3 + 4 + 2*NPORTS + 1 + 1;
  localparam logic [2:0] MAX_PORTS = 3'(NPORTS);
  localparam int         STRAP_W   = 3*NPORTS + SMB_ADDR_W;
  // Both sync stages must fill before straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic [NPORTS-1:0]     ss_en;
    logic [NPORTS-1:0]     hs_en;
    logic [NPORTS-1:0]     dis;
    logic [NPORTS-1:0]     fixed;
    logic [NPORTS-1:0]     chg;
    logic [2:0]            nports;
    logic                  pwr;
    logic                  oc;
    logic [3:0]            up_stat;
    logic [SMB_ADDR_W-1:0] smb;
    logic [7:0]            dsc;
    logic [7:0]            rdata;
    logic [NPORTS-1:0]     en;
    logic [NPORTS-1:0]     rem;
    logic [1:0]            strap_wait;
    logic                  strap_done;
  } hppsc_s;

  hppsc_s st_ff;
  hppsc_s nxt_st;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [2:0]        caps_s;
  logic [3:0]        stat_s;
  logic [NPORTS-1:0] req_s;
  logic [NPORTS-1:0] rel_s;
  logic              oc_s;
  logic              henable_s;

  logic [STRAP_W-1:0]    straps_s;
  logic [NPORTS-1:0]     strap_dis_s;
  logic [NPORTS-1:0]     strap_fixed_s;
  logic [NPORTS-1:0]     strap_chg_s;
  logic [SMB_ADDR_W-1:0] strap_smb_s;

  ////////////////////////////////////////////////////////////////
  // Over-current carried active high so the flops' reset value reads as no fault
  assign pins_raw = {up_link_caps, up_hs_connected, up_hs_suspended, up_ss_connected,
                     up_ss_suspended, port_power_req, port_power_release_ok,
                     ~over_current_n, host_power_enable};

  hppsc_sync #(.W(SYNC_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign {caps_s, stat_s, req_s, rel_s, oc_s, henable_s} = pins_s;

  // Straps are pins too; synchronised like the rest
  hppsc_sync #(.W(STRAP_W)) u_strap_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({strap_port_disable, strap_port_fixed, strap_port_charge, strap_smb_addr}),
    .q     (straps_s)
  );

  assign {strap_dis_s, strap_fixed_s, strap_chg_s, strap_smb_s} = straps_s;

  ////////////////////////////////////////////////////////////////

  // Clamp the reported port count into 1..NPORTS
  function automatic logic [2:0] clamp_ports(input logic [2:0] n);
    if (n == 3'h0) begin
      clamp_ports = 3'h1;
    end else if (n > MAX_PORTS) begin
      clamp_ports = MAX_PORTS;
    end else begin
      clamp_ports = n;
    end
  endfunction : clamp_ports

  function automatic logic [NPORTS-1:0] active_mask(input logic [2:0] n);
    logic [NPORTS-1:0] m;
    m = '0;
    for (int i = 0; i < NPORTS; i++) begin
      m[i] = (3'(i) < n);
    end
    active_mask = m;
  endfunction : active_mask

  always_comb begin
    logic [NPORTS-1:0] usable;
    logic              ss_ok;
    logic              hs_ok;
    usable = '0;
    ss_ok  = 1'b0;
    hs_ok  = 1'b0;
    nxt_st = st_ff;

    // Straps caught once after reset release, later loads override
    if (!st_ff.strap_done) begin
      if (st_ff.strap_wait == STRAP_SETTLE) begin
        nxt_st.dis        = strap_dis_s;
        nxt_st.fixed      = strap_fixed_s;
        nxt_st.chg        = strap_chg_s;
        nxt_st.smb        = strap_smb_s;
        nxt_st.nports     = MAX_PORTS;
        nxt_st.strap_done = 1'b1;
      end else begin
        nxt_st.strap_wait = st_ff.strap_wait + 2'h1;
      end
    end else if (cfg_wr) begin
      nxt_st.nports = clamp_ports(cfg_num_ports);
      nxt_st.dis    = cfg_port_disable;
      nxt_st.fixed  = cfg_port_fixed;
      nxt_st.chg    = cfg_port_charge;
      nxt_st.smb    = cfg_smb_addr;
    end

    // Registered so these outputs come straight from flops
    nxt_st.en  = active_mask(nxt_st.nports) & ~nxt_st.dis;
    nxt_st.rem = ~nxt_st.fixed;

    // EEPROM-sourced data never reaches the status/command register
    if (reg_wr && reg_addr == DSC_OFFSET && !cfg_from_eeprom) begin
      nxt_st.dsc = reg_wdata & DSC_RW_MASK;
    end

    nxt_st.rdata = (reg_addr == DSC_OFFSET) ? st_ff.dsc : 8'h00;

    usable = active_mask(st_ff.nports) & ~st_ff.dis;
    ss_ok  = caps_s[2];
    hs_ok  = caps_s[2] | caps_s[1];
    nxt_st.ss_en = ss_ok ? usable : '0;
    nxt_st.hs_en = hs_ok ? usable : '0;

    // Fault holds power off until the host drives enable low with the fault gone
    if (oc_s) begin
      nxt_st.oc = 1'b1;
    end else if (!henable_s) begin
      nxt_st.oc = 1'b0;
    end

    if (oc_s || st_ff.oc) begin
      nxt_st.pwr = 1'b0;
    end else if (|(req_s & usable)) begin
      nxt_st.pwr = 1'b1;
    end else if (&(rel_s | ~usable)) begin
      nxt_st.pwr = 1'b0;
    end

    nxt_st.up_stat = stat_s;
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff     <= '0;
      st_ff.dsc <= DSC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign port_ss_enable           = st_ff.ss_en;
  assign port_hs_enable           = st_ff.hs_en;
  assign port_enabled             = st_ff.en;
  assign port_removable           = st_ff.rem;
  assign charging_downstream_port = st_ff.chg;
  assign ports_reported           = st_ff.nports;
  assign port_power_on            = st_ff.pwr;
  assign over_current_latched     = st_ff.oc;
  assign {hs_up_connected, hs_up_suspended, ss_up_connected, ss_up_suspended} = st_ff.up_stat;
  assign smb_address              = st_ff.smb;
  assign reg_rdata                = st_ff.rdata;
  assign uuid                     = UUID_DEFAULT;
  // Translator count per port and buffers per translator are fixed
  assign multi_translator_hub     = 3'(TT_BUFFERS - 1);
endmodule : hppsc_top

// >>> hppsc_properties.sv
/* Port checker for hppsc_top, bound below.
   Assumes one clock and synchronous active-low reset. */
module hppsc_properties
  import hppsc_pkg::*;
#(
  parameter int NPORTS = NUM_PORTS
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [2:0]        up_link_caps,
  input wire logic              up_hs_connected,
  input wire logic              up_ss_connected,
  input wire logic              over_current_n,
  input wire logic              host_power_enable,
  input wire logic [NPORTS-1:0] port_ss_enable,
  input wire logic [NPORTS-1:0] port_hs_enable,
  input wire logic [2:0]        ports_reported,
  input wire logic              port_power_on,
  input wire logic              over_current_latched,
  input wire logic              hs_up_connected,
  input wire logic              ss_up_connected
);
  // Settles $past depth after each reset release
  logic [2:0] up_cnt_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) up_cnt_ff <= 3'h0;
    else if (up_cnt_ff != 3'h7) up_cnt_ff <= up_cnt_ff + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_no_ss; up_cnt_ff == 3'h7 && !$past(up_link_caps[2], 3) |-> port_ss_enable == '0;
  endproperty
  a_no_ss: assert property (p_no_ss) else $error("ss offered");
  property p_no_hs; up_cnt_ff == 3'h7 && $past(up_link_caps, 3) == 3'h1 |-> port_hs_enable == '0;
  endproperty
  a_no_hs: assert property (p_no_hs) else $error("hs offered");
  property p_nports; up_cnt_ff == 3'h7 |-> ports_reported inside {[3'h1:3'h4]}; endproperty
  a_nports: assert property (p_nports) else $error("port count");
  property p_oc_set; up_cnt_ff == 3'h7 && !$past(over_current_n, 3) |-> over_current_latched;
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("oc not latched");
  property p_oc_off; over_current_latched && $past(over_current_latched) |-> !port_power_on;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("power on in oc");
  property p_oc_hold; over_current_latched && host_power_enable && $past(host_power_enable)
    && $past(host_power_enable, 2) |=> over_current_latched; endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("oc cleared");
  property p_rst; disable iff (1'b0) !rst_n |=> !port_power_on && ports_reported == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_stat; up_cnt_ff == 3'h7 |-> hs_up_connected == $past(up_hs_connected, 3)
    && ss_up_connected == $past(up_ss_connected, 3); endproperty
  a_stat: assert property (p_stat) else $error("status out");
endmodule : hppsc_properties

bind hppsc_top hppsc_properties #(.NPORTS(NPORTS)) u_props (.clk, .rst_n, .up_link_caps,
  .up_hs_connected, .up_ss_connected, .over_current_n, .host_power_enable, .port_ss_enable,
  .port_hs_enable, .ports_reported, .port_power_on, .over_current_latched, .hs_up_connected,
  .ss_up_connected);

// >>> hppsc_host_model.sv
/* Upstream host stand-in: link capability and connect/suspend levels.
   Assumes the bench moves mode and suspend at the falling edge. */
module hppsc_host_model (
  input  wire logic [2:0] mode,
  input  wire logic       suspend,
  output logic      [2:0] up_link_caps,
  output logic            up_hs_connected,
  output logic            up_hs_suspended,
  output logic            up_ss_connected,
  output logic            up_ss_suspended
);
  assign up_link_caps    = mode;
  assign up_hs_connected = |mode[2:1];
  assign up_hs_suspended = |mode[2:1] & suspend;
  assign up_ss_connected = mode[2];
  assign up_ss_suspended = mode[2] & suspend;
endmodule : hppsc_host_model

// >>> hppsc_tb_top.sv
/* Self-checking bench for hppsc_top with the host stand-in.
   Assumes nothing outside; makes clock and reset itself. */
module hppsc_tb_top
  import hppsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, suspend, cfg_wr, cfg_from_eeprom, reg_wr, over_current_n;
  logic       host_power_enable, port_power_on, over_current_latched, hs_up_connected;
  logic       hs_up_suspended, ss_up_connected, ss_up_suspended, up_hs_connected;
  logic       up_hs_suspended, up_ss_connected, up_ss_suspended;
  logic [2:0] mode, up_link_caps, cfg_num_ports, ports_reported;
  logic [3:0] cfg_port_disable, cfg_port_fixed, cfg_port_charge, port_power_req;
  logic [3:0] port_power_release_ok, port_ss_enable, port_hs_enable, port_enabled;
  logic [3:0] port_removable, charging_downstream_port;
  logic [3:0] strap_port_disable, strap_port_fixed, strap_port_charge;
  logic [6:0] strap_smb_addr;
  logic [2:0] multi_translator_hub;
  logic [6:0] cfg_smb_addr, smb_address;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [127:0] uuid;
  int         n_errors, checks_done;
  hppsc_host_model host (.mode, .suspend, .up_link_caps, .up_hs_connected, .up_hs_suspended,
    .up_ss_connected, .up_ss_suspended);
  hppsc_top uut (.clk, .rst_n, .up_link_caps, .up_hs_connected, .up_hs_suspended,
    .up_ss_connected, .up_ss_suspended, .strap_port_disable, .strap_port_fixed,
    .strap_port_charge, .strap_smb_addr, .cfg_wr, .cfg_from_eeprom,
    .cfg_num_ports, .cfg_port_disable, .cfg_port_fixed, .cfg_port_charge, .cfg_smb_addr,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .port_power_req, .port_power_release_ok,
    .over_current_n, .host_power_enable, .port_ss_enable, .port_hs_enable, .port_enabled,
    .port_removable, .charging_downstream_port, .ports_reported, .port_power_on,
    .over_current_latched, .hs_up_connected, .hs_up_suspended, .ss_up_connected,
    .ss_up_suspended, .smb_address, .uuid, .multi_translator_hub);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [127:0] exp, logic [127:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic wr(logic [7:0] a, logic [7:0] d, logic ee);
    reg_addr = a; reg_wdata = d; cfg_from_eeprom = ee; reg_wr = 1'b1;
    wait_n(1);
    reg_wr = 1'b0; cfg_from_eeprom = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    wait_n(2);
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  task automatic t_speed;
    logic [2:0] m [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    foreach (m[i]) begin
      mode = m[i];
      wait_n(4);
      chk("ss_en", {4{m[i][2]}}, port_ss_enable);
      chk("hs_en", {4{|m[i][2:1]}}, port_hs_enable);
      chk("con", {|m[i][2:1], m[i][2]}, {hs_up_connected, ss_up_connected});
    end
    chk("susp", 2'h0, {hs_up_suspended, ss_up_suspended});
    suspend = 1'b1;
    wait_n(4);
    chk("susp", 2'h3, {hs_up_suspended, ss_up_suspended});
  endtask : t_speed
  task automatic t_cfg;
    logic [2:0] n [3] = '{3'h4, 3'h0, 3'h5};
    logic [2:0] e [3] = '{3'h4, 3'h1, 3'h4};
    logic [3:0] en [3] = '{4'hb, 4'h1, 4'hb};
    cfg_port_disable = 4'h4; cfg_port_fixed = 4'h1; cfg_port_charge = 4'ha; cfg_smb_addr = 7'h2a;
    foreach (n[i]) begin
      cfg_num_ports = n[i]; cfg_wr = 1'b1;
      wait_n(1);
      cfg_wr = 1'b0;
      wait_n(2);
      chk("reported", e[i], ports_reported);
      chk("enabled", en[i], port_enabled);
    end
    chk("enabled", 4'hb, port_enabled);
    chk("removable", 4'he, port_removable);
    chk("charge", 4'ha, charging_downstream_port);
    chk("smb", 7'h2a, smb_address);
  endtask : t_cfg
  task automatic t_power;
    port_power_req = 4'h8;
    wait_n(4);
    chk("pwr", 1'b1, port_power_on);
    port_power_req = 4'h0; port_power_release_ok = 4'h7;
    wait_n(4);
    chk("pwr", 1'b1, port_power_on);
    port_power_release_ok = 4'hf;
    wait_n(4);
    chk("pwr", 1'b0, port_power_on);
  endtask : t_power
  task automatic t_oc;
    port_power_req = 4'h1;
    wait_n(4);
    over_current_n = 1'b0;
    wait_n(4);
    chk("oc", 2'h2, {over_current_latched, port_power_on});
    over_current_n = 1'b1;
    wait_n(6);
    chk("oc", 2'h2, {over_current_latched, port_power_on});
    host_power_enable = 1'b0;
    wait_n(4);
    chk("oc", 1'b0, over_current_latched);
    host_power_enable = 1'b1;
    wait_n(4);
    chk("pwr", 1'b1, port_power_on);
  endtask : t_oc
  task automatic t_reg;
    rd(8'hf8, 8'h00);
    wr(8'hf8, 8'hff, 1'b0);
    rd(8'hf8, 8'h03);
    wr(8'hf8, 8'h00, 1'b1);
    rd(8'hf8, 8'h03);
    wr(8'h10, 8'h55, 1'b0);
    rd(8'h10, 8'h00);
    chk("uuid", UUID_DEFAULT, uuid);
    chk("translators", 3'(TT_BUFFERS - 1), multi_translator_hub);
  endtask : t_reg
  task automatic t_rst;
    strap_port_disable = 4'h2;
    strap_port_fixed = 4'h4;
    strap_port_charge = 4'h1;
    rst_n = 1'b0;
    wait_n(1);
    chk("rst", 5'h00, {port_power_on, over_current_latched, ports_reported});
    rst_n = 1'b1;
    wait_n(8);
    rd(8'hf8, 8'h00);
    chk("smb", 7'h11, smb_address);
    chk("reported", 3'h4, ports_reported);
    chk("enabled", 4'hd, port_enabled);
    chk("removable", 4'hb, port_removable);
    chk("charge", 4'h1, charging_downstream_port);
  endtask : t_rst
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Run needs about 100 cycles; allow ample slack
  initial begin
    #(3000 * 100);
    n_errors++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0; mode = 3'h7; suspend = 1'b0; cfg_wr = 1'b0; cfg_from_eeprom = 1'b0;
    reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; over_current_n = 1'b1;
    host_power_enable = 1'b1; cfg_num_ports = 3'h4; cfg_port_disable = 4'h0;
    cfg_port_fixed = 4'h0; cfg_port_charge = 4'h0; cfg_smb_addr = 7'h00;
    port_power_req = 4'h0; port_power_release_ok = 4'h0; n_errors = 0; checks_done = 0;
    strap_port_disable = 4'h0;
    strap_port_fixed = 4'h0;
    strap_port_charge = 4'h0;
    strap_smb_addr = 7'h11;
    wait_n(3);
    rst_n = 1'b1;
    wait_n(8);
    t_reg();
    t_speed();
    t_cfg();
    t_power();
    t_oc();
    t_rst();
    wrap_up();
  end
endmodule : hppsc_tb_top
